// >>> dma_channel_mode_control.sv
// DMA channel control registers, address stepping, strobe pins, data FIFO
`timescale 1ns/1ns

module dma_data_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire full = (wr_ptr[AW] != rd_ptr[AW]) &&
        (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire push = i_in_valid && !full;
    wire pop = i_out_ready && !empty;

    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = mem[rd_ptr[AW-1:0]];

    // Storage, written only on an accepted push
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= i_in_data;
        end
    end

    // Pointers with one wrap bit each
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
        end
    end
endmodule

module dma_channel_mode_control
    import dma_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_standby,
    // CPU register port
    input wire logic i_bus_sel,
    input wire logic i_bus_wr,
    input wire logic [7:0] i_bus_addr,
    input wire logic [3:0] i_bus_be,
    input wire logic [31:0] i_bus_wdata,
    output logic [31:0] o_bus_rdata,
    output logic o_bus_ack,
    // Transfer engine events, one bit per channel, and initial addresses shared by all channels
    input wire logic [3:0] i_addr_load,
    input wire logic [31:0] i_src_init,
    input wire logic [31:0] i_dst_init,
    input wire logic [3:0] i_unit_done,
    input wire logic [3:0] i_count_done,
    // Channel state toward the transfer engine
    output logic [127:0] o_src_addr,
    output logic [127:0] o_dst_addr,
    output logic [3:0] o_chan_enable,
    output logic [3:0] o_irq_request,
    // External request pins, channels 0 and 1
    input wire logic [1:0] i_transfer_request_input,
    output logic [1:0] o_request_detect,
    input wire logic [1:0] i_req_accept,
    output logic [1:0] o_request_accept_strobe,
    input wire logic [1:0] i_ack_window,
    input wire logic [1:0] i_dual_mode,
    input wire logic i_cycle_is_write,
    output logic [1:0] o_transfer_acknowledge_strobe,
    // Data stream through the FIFO
    input wire logic i_data_valid,
    input wire logic [31:0] i_data,
    output logic o_data_ready,
    output logic o_out_valid,
    output logic [31:0] o_out_data,
    input wire logic i_out_ready
);
    logic [1:0] rst_pipe;
    logic rst_n;
    logic [31:0] ctrl [CHANNELS];
    logic [3:0] te_seen;
    logic [31:0] src_init [CHANNELS];
    logic [31:0] rd_term [CHANNELS];
    logic [31:0] next_rdata;
    logic [1:0] transfer_request_input_meta;
    logic [1:0] transfer_request_input_sync;
    logic [1:0] transfer_request_input_prev;

    // Step for one channel from its mode, unit size and pointer mode
    function automatic logic [31:0] step_of(input logic [1:0] mode,
        input logic [1:0] size, input logic indirect);
        logic [31:0] mag;
        logic [31:0] step;
        mag = STEP_BYTE;
        step = 32'h0000_0000;
        case (size)
            SIZE_BYTE: mag = STEP_BYTE;
            SIZE_WORD: mag = STEP_WORD;
            SIZE_LONG: mag = STEP_LONG;
            default: mag = STEP_BLOCK;
        endcase
        if (indirect) begin
            mag = STEP_INDIRECT;
        end
        case (mode)
            STEP_INC: step = mag;
            STEP_DEC: begin
                if (size == SIZE_BLOCK && !indirect) begin
                    step = 32'h0000_0000;
                end else begin
                    step = ~mag + 32'h0000_0001;
                end
            end
            default: step = 32'h0000_0000;
        endcase
        return step;
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Byte lane mask and bus strobes
    wire [31:0] lane_mask = {{8{i_bus_be[3]}}, {8{i_bus_be[2]}},
        {8{i_bus_be[1]}}, {8{i_bus_be[0]}}};
    wire bus_write = i_bus_sel && i_bus_wr;
    wire bus_read = i_bus_sel && !i_bus_wr;
    // Engine is frozen in standby; address counters hold, CPU writes to control registers still land
    wire run = !i_standby;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            wire hit = (i_bus_addr == CONTROL_OFS[ch*8 +: 8]);
            // Only implemented bits of this channel take writes
            wire [31:0] impl_mask = COMMON_MASK | CHAN_MASKS[ch*32 +: 32];
            wire [31:0] wr_mask = impl_mask & lane_mask;
            wire [31:0] cur = ctrl[ch];
            wire te = cur[TE_BIT];
            wire te_clear = bus_write && hit && i_bus_be[0] &&
                !i_bus_wdata[TE_BIT] && te_seen[ch];
            wire te_set = run && i_count_done[ch];
            wire next_te = te_set || (te && !te_clear);
            wire [31:0] written = bus_write && hit ?
                ((cur & ~wr_mask) | (i_bus_wdata & wr_mask)) : cur;
            wire [31:0] next_ctrl = (written & impl_mask) |
                ({31'h0, next_te} << TE_BIT);
            wire indirect = cur[POINTER_MODE_BIT];
            wire [1:0] size = cur[UNIT_SIZE_LSB +: 2];
            wire [31:0] s_step = step_of(cur[SRC_STEP_LSB +: 2], size,
                indirect);
            wire [31:0] d_step = step_of(cur[DEST_STEP_LSB +: 2], size,
                1'b0);
            wire reload = cur[SOURCE_RELOAD_BIT] && i_count_done[ch];
            wire [31:0] src_now = o_src_addr[ch*32 +: 32];
            wire [31:0] dst_now = o_dst_addr[ch*32 +: 32];
            wire [31:0] next_src = !run ? src_now :
                i_addr_load[ch] ? i_src_init :
                reload ? src_init[ch] :
                i_unit_done[ch] ? src_now + s_step : src_now;
            wire [31:0] next_dst = !run ? dst_now :
                i_addr_load[ch] ? i_dst_init :
                i_unit_done[ch] ? dst_now + d_step : dst_now;
            wire next_seen = next_te && (te_seen[ch] ||
                (bus_read && hit && te));

            assign rd_term[ch] = (bus_read && hit) ? cur : 32'h0;

            // Control register and transfer-end handshake state
            always_ff @(posedge i_core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl[ch] <= CONTROL_RESET;
                    te_seen[ch] <= 1'b0;
                end else begin
                    ctrl[ch] <= next_ctrl;
                    te_seen[ch] <= next_seen;
                end
            end

            // Address counters and the saved initial source
            always_ff @(posedge i_core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    o_src_addr[ch*32 +: 32] <= 32'h0;
                    o_dst_addr[ch*32 +: 32] <= 32'h0;
                    src_init[ch] <= 32'h0;
                end else begin
                    o_src_addr[ch*32 +: 32] <= next_src;
                    o_dst_addr[ch*32 +: 32] <= next_dst;
                    if (run && i_addr_load[ch]) begin
                        src_init[ch] <= i_src_init;
                    end
                end
            end

            // Enable and completion request toward the engine
            always_ff @(posedge i_core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    o_chan_enable[ch] <= 1'b0;
                    o_irq_request[ch] <= 1'b0;
                end else begin
                    o_chan_enable[ch] <= next_ctrl[CHAN_EN_BIT];
                    o_irq_request[ch] <= next_te &&
                        next_ctrl[IRQ_EN_BIT];
                end
            end
        end
    endgenerate

    // Read data gathers the addressed channel; unmapped reads give zero
    always_comb begin
        next_rdata = 32'h0;
        for (int i = 0; i < CHANNELS; i++) begin
            next_rdata = next_rdata | rd_term[i];
        end
    end

    // Bus answer one cycle after the access
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_bus_rdata <= 32'h0;
            o_bus_ack <= 1'b0;
        end else begin
            o_bus_rdata <= next_rdata;
            o_bus_ack <= i_bus_sel;
        end
    end

    // Request pin synchroniser and edge history
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            transfer_request_input_meta <= 2'b11;
            transfer_request_input_sync <= 2'b11;
            transfer_request_input_prev <= 2'b11;
        end else begin
            transfer_request_input_meta <= i_transfer_request_input;
            transfer_request_input_sync <= transfer_request_input_meta;
            transfer_request_input_prev <= transfer_request_input_sync;
        end
    end

    // Pin logic for channels 0 and 1
    generate
        for (ch = 0; ch < 2; ch++) begin : g_pin
            wire [31:0] cur = ctrl[ch];
            wire detect = cur[REQ_EDGE_BIT] ?
                (transfer_request_input_prev[ch] && !transfer_request_input_sync[ch]) : !transfer_request_input_sync[ch];
            wire accept_lvl = cur[REQ_ACCEPT_POL_BIT] ?
                i_req_accept[ch] : !i_req_accept[ch];
            wire in_phase = !i_dual_mode[ch] ||
                (i_cycle_is_write == cur[ACK_PHASE_BIT]);
            wire ack_act = i_ack_window[ch] && in_phase;
            wire ack_lvl = cur[ACK_POL_BIT] ?
                ack_act : !ack_act;

            // Registered pin outputs, strobes idle high and request detect low after reset
            always_ff @(posedge i_core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    o_request_detect[ch] <= 1'b0;
                    o_request_accept_strobe[ch] <= 1'b1;
                    o_transfer_acknowledge_strobe[ch] <= 1'b1;
                end else begin
                    o_request_detect[ch] <= detect;
                    o_request_accept_strobe[ch] <= accept_lvl;
                    o_transfer_acknowledge_strobe[ch] <= ack_lvl;
                end
            end
        end
    endgenerate

    // Data path buffer
    dma_data_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_in_valid(i_data_valid),
        .i_in_data(i_data),
        .o_in_ready(o_data_ready),
        .o_out_valid(o_out_valid),
        .o_out_data(o_out_data),
        .i_out_ready(i_out_ready)
    );
endmodule

// >>> dma_ctrl_pkg.sv
// Constants and types for the four-channel DMA channel control logic
package dma_ctrl_pkg;
    localparam int CHANNELS = 4;
    localparam int FIFO_WIDTH = 32;
    localparam int FIFO_DEPTH = 16;

    // Byte offsets of the channel control registers, channel 0 lowest
    localparam logic [31:0] CONTROL_OFS = {8'h5C, 8'h4C, 8'h3C, 8'h2C};
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

    // Field positions
    localparam int POINTER_MODE_BIT = 20;
    localparam int SOURCE_RELOAD_BIT = 19;
    localparam int REQ_ACCEPT_POL_BIT = 18;
    localparam int ACK_PHASE_BIT = 17;
    localparam int ACK_POL_BIT = 16;
    localparam int DEST_STEP_LSB = 14;
    localparam int SRC_STEP_LSB = 12;
    localparam int REQ_EDGE_BIT = 6;
    localparam int UNIT_SIZE_LSB = 3;
    localparam int IRQ_EN_BIT = 2;
    localparam int TE_BIT = 1;
    localparam int CHAN_EN_BIT = 0;

    // Plain writable bits of every channel, transfer-end flag excluded
    localparam logic [31:0] COMMON_MASK = 32'h0000_FF3D;
    // Extra writable bits per channel, channel 0 lowest
    localparam logic [127:0] CHAN_MASKS = {
        32'h0010_0000, 32'h0008_0000, 32'h0007_0040, 32'h0007_0040};

    // Address step magnitudes
    localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] STEP_WORD = 32'h0000_0002;
    localparam logic [31:0] STEP_LONG = 32'h0000_0004;
    localparam logic [31:0] STEP_BLOCK = 32'h0000_0010;
    localparam logic [31:0] STEP_INDIRECT = 32'h0000_0004;

    typedef enum logic [1:0] {
        STEP_FIXED = 2'b00,
        STEP_INC = 2'b01,
        STEP_DEC = 2'b10,
        STEP_BAD = 2'b11
    } step_mode_t;

    typedef enum logic [1:0] {
        SIZE_BYTE = 2'b00,
        SIZE_WORD = 2'b01,
        SIZE_LONG = 2'b10,
        SIZE_BLOCK = 2'b11
    } unit_size_t;
endpackage

// >>> dma_channel_mode_control_asserts.sv
// Port checks for the DMA channel control block
`timescale 1ns/1ns
module dma_channel_mode_control_asserts (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_standby,
    // Register port
    input wire logic i_bus_sel,
    input wire logic i_bus_wr,
    input wire logic [7:0] i_bus_addr,
    input wire logic [31:0] o_bus_rdata,
    input wire logic o_bus_ack,
    // Engine events and state
    input wire logic [3:0] i_addr_load,
    input wire logic [3:0] i_unit_done,
    input wire logic [3:0] i_count_done,
    input wire logic [127:0] o_src_addr,
    input wire logic [127:0] o_dst_addr,
    input wire logic [3:0] o_irq_request,
    // FIFO drain
    input wire logic o_out_valid,
    input wire logic [31:0] o_out_data,
    input wire logic i_out_ready
);
    logic [31:0] absent;
    logic ev0;
    // Bits missing from the addressed channel
    assign absent = (i_bus_addr == 8'h4C) ? 32'h0017_0040 :
        (i_bus_addr == 8'h5C) ? 32'h000F_0040 : 32'h0018_0000;
    assign ev0 = i_addr_load[0] | i_unit_done[0];
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    a_ack_follows: assert property (i_bus_sel |=> o_bus_ack)
        else $error("no ack after select");
    a_write_zero: assert property (o_bus_ack && $past(i_bus_wr)
        |-> o_bus_rdata == 32'h0) else $error("write returned data");
    a_reserved_zero:
        assert property (o_bus_ack |-> (o_bus_rdata & 32'hFFE0_0080) == 32'h0)
        else $error("reserved bits read nonzero");
    a_chan_absent:
        assert property (i_bus_sel && !i_bus_wr
        |=> (o_bus_rdata & $past(absent)) == 32'h0)
        else $error("absent channel bit read nonzero");
    a_standby_hold:
        assert property (i_standby
        |=> $stable(o_src_addr) && $stable(o_dst_addr))
        else $error("addresses moved in standby");
    a_step_cause:
        assert property (!ev0
        |=> $stable(o_src_addr[31:0]) && $stable(o_dst_addr[31:0]))
        else $error("address moved without event");
    a_irq_cause:
        assert property ($rose(o_irq_request[1])
        |-> $past(i_count_done[1]) || $past(i_bus_sel && i_bus_wr))
        else $error("irq rose without cause");
    a_fifo_hold: assert property (o_out_valid && !i_out_ready
        |=> o_out_valid && $stable(o_out_data))
        else $error("fifo output dropped while stalled");
endmodule
bind dma_channel_mode_control dma_channel_mode_control_asserts
    dma_channel_mode_control_asserts_inst (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_standby(i_standby),
    .i_bus_sel(i_bus_sel), .i_bus_wr(i_bus_wr), .i_bus_addr(i_bus_addr),
    .o_bus_rdata(o_bus_rdata), .o_bus_ack(o_bus_ack),
    .i_addr_load(i_addr_load), .i_unit_done(i_unit_done),
    .i_count_done(i_count_done), .o_src_addr(o_src_addr),
    .o_dst_addr(o_dst_addr), .o_irq_request(o_irq_request),
    .o_out_valid(o_out_valid), .o_out_data(o_out_data),
    .i_out_ready(i_out_ready));

// >>> dma_periph_model.sv
// Peripheral that raises a request and waits for its acceptance
`timescale 1ns/1ns
module dma_periph_model (
    // Clock
    input wire logic i_core_clk,
    // Bench control
    input wire logic i_start,
    input wire logic i_active_high,
    output logic o_served,
    // Request pins
    input wire logic i_accept,
    output logic o_req_n
);
    initial begin
        o_req_n = 1'b1;
        o_served = 1'b0;
    end
    // Hold request low until the accept strobe is active
    always @(posedge i_core_clk) begin
        if (i_start) begin
            o_req_n <= 1'b0;
            o_served <= 1'b0;
        end else if (!o_req_n && i_accept == i_active_high) begin
            o_req_n <= 1'b1;
            o_served <= 1'b1;
        end
    end
endmodule

// >>> dma_channel_mode_control_tb.sv
// Self-checking bench for the DMA channel control block
`timescale 1ns/1ns
module dma_channel_mode_control_tb
    import dma_ctrl_pkg::*;
();
    logic clk = 1'b0, rst_n = 1'b0, stby = 1'b0, sel = 1'b0, wr = 1'b0;
    logic [7:0] addr = 8'h00, a;
    logic [3:0] be = 4'h0, ld = 4'h0, ud = 4'h0, cd = 4'h0, irq;
    logic [31:0] wd = 32'h0, si = 32'h0, di = 32'h0, din = 32'h0;
    logic [31:0] rd, dout, vs, vd;
    logic [1:0] acc = 2'h0, win = 2'h0, dual = 2'h0, det, rak, tak;
    logic cw = 1'b0, dv = 1'b0, ordy = 1'b0, go = 1'b0, pol = 1'b0;
    logic [127:0] sa, da;
    logic [3:0] en;
    logic ack, drdy, ov, req0, served;
    logic [31:0] mreg [4] = '{4{32'h0}};
    logic te [4] = '{4{1'b0}}, seen [4] = '{4{1'b0}};
    logic [31:0] q [$];
    int bad_count = 0, compares = 0, cyc = 0, c;
    dma_channel_mode_control dma_channel_mode_control_inst (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_standby(stby),
        .i_bus_sel(sel), .i_bus_wr(wr), .i_bus_addr(addr), .i_bus_be(be),
        .i_bus_wdata(wd), .o_bus_rdata(rd), .o_bus_ack(ack),
        .i_addr_load(ld), .i_src_init(si), .i_dst_init(di),
        .i_unit_done(ud), .i_count_done(cd), .o_src_addr(sa),
        .o_dst_addr(da), .o_chan_enable(en), .o_irq_request(irq),
        .i_transfer_request_input({1'b1, req0}), .o_request_detect(det),
        .i_req_accept(acc), .o_request_accept_strobe(rak),
        .i_ack_window(win), .i_dual_mode(dual), .i_cycle_is_write(cw),
        .o_transfer_acknowledge_strobe(tak), .i_data_valid(dv),
        .i_data(din), .o_data_ready(drdy), .o_out_valid(ov),
        .o_out_data(dout), .i_out_ready(ordy));
    dma_periph_model dma_periph_model_inst (.i_core_clk(clk),
        .i_start(go), .i_active_high(pol), .o_served(served),
        .i_accept(rak[0]), .o_req_n(req0));
    initial forever #4 clk = ~clk;
    // Engine accepts any detected request; timeout guard
    always @(posedge clk) begin
        acc <= det;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // One register access: select for one cycle, ack follows
    task automatic bus(input logic w, input logic [7:0] ad,
        input logic [3:0] b, input logic [31:0] d);
        @(posedge clk);
        {sel, wr, addr, be, wd} <= {1'b1, w, ad, b, d};
        @(posedge clk);
        sel <= 1'b0;
        #1;
        chk({31'h0, ack}, 32'h1);
    endtask
    task automatic wrc(input int ch, input logic [31:0] d,
        input logic [3:0] b);
        logic [31:0] m;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        if (b[0] && !d[1] && seen[ch]) begin
            te[ch] = 1'b0;
            seen[ch] = 1'b0;
        end
        m = m & (COMMON_MASK | CHAN_MASKS[ch*32+:32]);
        mreg[ch] = (mreg[ch] & ~m) | (d & m);
        bus(1'b1, CONTROL_OFS[ch*8+:8], b, d);
    endtask
    task automatic rdc(input int ch);
        bus(1'b0, CONTROL_OFS[ch*8+:8], 4'hF, 32'h0);
        chk(rd, mreg[ch] | {30'h0, te[ch], 1'b0});
        seen[ch] = te[ch];
    endtask
    // Event pulse: 0 load, 1 unit done, 2 count done
    task automatic pulse(input int k, input int ch);
        @(posedge clk);
        {si, di} <= {vs, vd};
        if (k == 0) ld[ch] <= 1'b1;
        else if (k == 1) ud[ch] <= 1'b1;
        else cd[ch] <= 1'b1;
        if (k == 2 && !stby) te[ch] = 1'b1;
        @(posedge clk);
        {ld, ud, cd} <= 12'h0;
        #1;
    endtask
    function automatic logic [31:0] stp(int m, int s, logic ind);
        logic [31:0] u;
        u = ind ? 32'h4 : (s == 3 ? 32'h10 : 32'h1 << s);
        if (m == 1) return u;
        if (m == 2 && (ind || s != 3)) return -u;
        return 32'h0;
    endfunction
    initial begin
        void'($urandom(18));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rdc(i);
            wrc(i, 32'hFFFF_FFFD, 4'hF);
            rdc(i);
            chk({31'h0, en[i]}, {31'h0, mreg[i][0]});
            wrc(i, 32'h0000_0002, 4'hF);
            rdc(i);
        end
        // Random lane writes within the defined bits, unmapped reads
        repeat (24) begin
            c = $urandom_range(3);
            wrc(c, $urandom & 32'h001F_FF7D, 4'($urandom));
            rdc(c);
            a = 8'($urandom);
            if (!(a inside {8'h2C, 8'h3C, 8'h4C, 8'h5C})) begin
                bus(1'b0, a, 4'hF, 32'h0);
                chk(rd, 32'h0);
            end
        end
        // Every step mode and unit size on every channel, direct only
        // Decrement with 16-byte units does not step the address here
        for (int i = 0; i < 4; i++)
            for (int s = 0; s < 4; s++)
                for (int m = 0; m < 4; m++) begin
                    wrc(i, (m << 14) | (m << 12) | (s << 3), 4'hF);
                    vs = $urandom;
                    vd = $urandom;
                    pulse(0, i);
                    pulse(1, i);
                    chk(sa[i*32+:32], vs + stp(m, s, 0));
                    chk(da[i*32+:32], vd + stp(m, s, 0));
                end
        wrc(3, 32'h0010_1000, 4'hF);
        pulse(0, 3);
        pulse(1, 3);
        chk(sa[127:96], vs + stp(1, 0, 1));
        wrc(2, 32'h0008_1000, 4'hF);
        pulse(0, 2);
        pulse(1, 2);
        pulse(2, 2);
        chk(sa[95:64], vs);
        rdc(2);
        wrc(2, 32'h0000_1000, 4'hF);
        pulse(1, 2);
        pulse(2, 2);
        chk(sa[95:64], vs + 1);
        wrc(1, 32'h0000_0006, 4'hF);
        rdc(1);
        pulse(2, 1);
        chk({31'h0, irq[1]}, 32'h1);
        wrc(1, 32'h0000_0004, 4'hF);
        rdc(1);
        wrc(1, 32'h0000_0004, 4'hF);
        rdc(1);
        chk({31'h0, irq[1]}, 32'h0);
        @(posedge clk);
        stby <= 1'b1;
        pulse(0, 0);
        pulse(1, 1);
        pulse(2, 3);
        for (int i = 0; i < 4; i++) rdc(i);
        stby <= 1'b0;
        // Acknowledge strobe phase and polarity
        for (int k = 0; k < 16; k++) begin
            wrc(0, (k & 3) << 16, 4'hF);
            {win, dual, cw} <= {2'h1, 1'b0, !k[3], k[2]};
            repeat (2) @(posedge clk);
            #1;
            chk({31'h0, tak[0]}, (k[3] || k[2] == k[1]) ? k[0] : !k[0]);
        end
        win <= 2'h0;
        // Request accept strobe with the peripheral model
        for (int p = 0; p < 2; p++) begin
            wrc(0, p << 18, 4'hF);
            // Strobe is registered from the updated control bit
            @(posedge clk);
            #1;
            chk({31'h0, rak[0]}, {31'h0, !p[0]});
            @(posedge clk);
            {go, pol} <= {1'b1, p[0]};
            @(posedge clk);
            go <= 1'b0;
            for (int n = 0; n < 20 && served !== 1'b1; n++) @(posedge clk);
            chk({31'h0, served}, 32'h1);
            repeat (8) @(posedge clk);
        end
        // Fill the FIFO against a stalled drain, then empty it
        dv <= 1'b1;
        din <= $urandom;
        repeat (24) begin
            @(posedge clk);
            if (drdy) begin
                q.push_back(din);
                din <= $urandom;
            end
        end
        dv <= 1'b0;
        chk(32'(q.size()), FIFO_DEPTH);
        ordy <= 1'b1;
        for (int n = 0; n < 40 && q.size() > 0; n++) begin
            @(posedge clk);
            if (ov) chk(dout, q.pop_front());
        end
        #1;
        chk({31'h0, ov}, 32'h0);
        wrap_up();
    end
endmodule
